// ### pkg/serial_port_pkg.sv
// Register map, field positions and reset values of the serial master/slave port.
// Assumes a 32-bit AXI4-Lite register bus; printed offsets are word indices.
package serial_port_pkg;
   // Printed offsets are not multiples of four: they are indices, address is four times
   localparam logic [7:0]  DATA_INDEX      = 8'h31;
   localparam logic [7:0]  CTRL_INDEX      = 8'h32;
   localparam logic [7:0]  STATUS_INDEX    = 8'h33;
   localparam logic [11:0] DATA_ADDR       = {2'b00, DATA_INDEX, 2'b00};
   localparam logic [11:0] CTRL_ADDR       = {2'b00, CTRL_INDEX, 2'b00};
   localparam logic [11:0] STATUS_ADDR     = {2'b00, STATUS_INDEX, 2'b00};
   // Control fields
   localparam int CTRL_IRQ_EN     = 7;
   localparam int CTRL_PERIPH_EN  = 6;
   localparam int CTRL_DIV_EN     = 5;
   localparam int CTRL_MASTER     = 4;
   localparam int CTRL_POLARITY   = 3;
   localparam int CTRL_PHASE      = 2;
   localparam int CTRL_RATE_HI    = 1;
   localparam int CTRL_RATE_LO    = 0;
   // Status fields
   localparam int STAT_DONE       = 7;
   localparam int STAT_COLLISION  = 6;
   localparam int STAT_OVERRUN    = 5;
   localparam int STAT_MODE_FAULT = 4;
   localparam int STAT_OUT_DIS    = 2;
   localparam int STAT_SOFT_MGMT  = 1;
   localparam int STAT_SOFT_LEVEL = 0;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET   = 8'h00;
   localparam int BITS_PER_BYTE = 8;
   localparam logic [1:0] AXI_OKAY   = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage : serial_port_pkg

// ### core/serial_port.sv
// Byte-wide serial master/slave port with three registers on AXI4-Lite.
// Assumes serial pins are synchronous to CORE_CLK and the far device obeys the settings.
//
// Overview of operation
// - Enabled done, fault, overrun flags raise interrupt
// - Enable bit gates pins; cleared on fault
// - Master bit drives clock; cleared on fault
// - Polarity bit sets clock idle level
// - Phase bit picks first or second edge
// - Three rate bits divide clock 4 to 128
// - Rate bits ignored in slave mode
// - Control upper bits reset to zero
// - Done flag set per byte, cleared by sequence
// - Data writes ignored while done, until status read or written
// - Write during transfer sets collision, discarded
// - Overrun set when byte arrives while done
// - Fault on select low as master; sequence clears
// - Output disable stops serial data output
// - Software select replaces pin when managed
// - Received byte copied to buffer; reads buffer
// - Data write loads shifter; master starts
// - Both ends share polarity and phase
// - Collision flag raises no interrupt
// - Fault blocks setting enable and master bits
// - Overrun keeps first byte, later bytes lost
//
// Added by the designer: the AXI4-Lite register port.
module serial_port (
   input  wire logic        CORE_CLK,
   input  wire logic        RST_B,
   input  wire logic [11:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [11:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   input  wire logic        SCK_I,
   output logic             SCK_O,
   output logic             SCK_OE_N,
   input  wire logic        MOSI_I,
   output logic             MOSI_O,
   output logic             MOSI_OE_N,
   input  wire logic        MISO_I,
   output logic             MISO_O,
   output logic             MISO_OE_N,
   input  wire logic        SS_N_I,
   output logic             PINS_ALT_EN,
   output logic             SS_PIN_ALT_EN,
   output logic             IRQ
);
   typedef enum logic [1:0] {IDLE, RUN} xfer_e;

   logic [7:0]  ctrl_reg;
   logic        done_reg, coll_reg, ovr_reg, fault_reg;
   logic        out_dis_reg, soft_mgmt_reg, soft_level_reg;
   logic        done_armed_reg, fault_armed_reg, coll_armed_reg;
   logic [7:0]  shift_reg, rx_buf_reg;
   logic        in_reg;
   xfer_e       state_reg;
   logic [3:0]  edge_cnt_reg;
   logic [6:0]  div_cnt_reg;
   logic        sck_reg;
   logic        sck_in_prev_reg;
   logic        ss_in_prev_reg;

   // AXI write and read channel holding registers
   logic        aw_held_reg, w_held_reg;
   logic [11:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rdata_reg;

   logic master, enabled, sel_n, fault_event;
   logic wr_fire, rd_fire, wr_data, wr_ctrl, wr_stat, rd_data, rd_stat;
   logic data_load, byte_end, sample_edge, shift_edge, master_tick;
   logic [6:0] half_period;
   logic [7:0] status_view;

   function automatic logic [6:0] half_div(input logic [2:0] rate);
      unique case (rate)
         3'b100:  half_div = 7'd1;
         3'b000:  half_div = 7'd3;
         3'b001:  half_div = 7'd7;
         3'b110:  half_div = 7'd15;
         3'b010:  half_div = 7'd31;
         3'b011:  half_div = 7'd63;
         default: half_div = 7'd63;
      endcase
   endfunction : half_div

   assign master  = ctrl_reg[serial_port_pkg::CTRL_MASTER];
   assign enabled = ctrl_reg[serial_port_pkg::CTRL_PERIPH_EN];
   assign sel_n   = soft_mgmt_reg ? soft_level_reg : SS_N_I;
   assign fault_event = master && enabled && !sel_n;

   assign status_view = {done_reg, coll_reg, ovr_reg, fault_reg, 1'b0,
                         out_dis_reg, soft_mgmt_reg, soft_level_reg};

   // AXI slave: accept address and data in either order, answer after both
   assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
   assign S_AXI_WREADY  = !w_held_reg && !bvalid_reg;
   assign S_AXI_ARREADY = !rvalid_reg;
   assign S_AXI_BVALID  = bvalid_reg;
   assign S_AXI_BRESP   = bresp_reg;
   assign S_AXI_RVALID  = rvalid_reg;
   assign S_AXI_RRESP   = rresp_reg;
   assign S_AXI_RDATA   = rdata_reg;

   assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_data = wr_fire && wstrb_reg[0] && awaddr_reg == serial_port_pkg::DATA_ADDR;
   assign wr_ctrl = wr_fire && wstrb_reg[0] && awaddr_reg == serial_port_pkg::CTRL_ADDR;
   assign wr_stat = wr_fire && wstrb_reg[0] && awaddr_reg == serial_port_pkg::STATUS_ADDR;
   assign rd_fire = S_AXI_ARVALID && !rvalid_reg;
   assign rd_data = rd_fire && S_AXI_ARADDR == serial_port_pkg::DATA_ADDR;
   assign rd_stat = rd_fire && S_AXI_ARADDR == serial_port_pkg::STATUS_ADDR;

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         awaddr_reg  <= 12'h000;
         wdata_reg   <= 32'h0000_0000;
         wstrb_reg   <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= serial_port_pkg::AXI_OKAY;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= S_AXI_WDATA;
            wstrb_reg  <= S_AXI_WSTRB;
         end
         if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= (awaddr_reg == serial_port_pkg::DATA_ADDR ||
                            awaddr_reg == serial_port_pkg::CTRL_ADDR ||
                            awaddr_reg == serial_port_pkg::STATUS_ADDR)
                           ? serial_port_pkg::AXI_OKAY : serial_port_pkg::AXI_SLVERR;
         end else if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= serial_port_pkg::AXI_OKAY;
         rdata_reg  <= 32'h0000_0000;
      end else if (rd_fire) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= serial_port_pkg::AXI_OKAY;
         unique case (S_AXI_ARADDR)
            serial_port_pkg::DATA_ADDR:   rdata_reg <= {24'h00_0000, rx_buf_reg};
            serial_port_pkg::CTRL_ADDR:   rdata_reg <= {24'h00_0000, ctrl_reg};
            serial_port_pkg::STATUS_ADDR: rdata_reg <= {24'h00_0000, status_view};
            default: begin
               rdata_reg <= 32'h0000_0000;
               rresp_reg <= serial_port_pkg::AXI_SLVERR;
            end
         endcase
      end else if (rvalid_reg && S_AXI_RREADY) begin
         rvalid_reg <= 1'b0;
      end
   end

   // Control register; low bits reset to zero where hardware leaves them open
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ctrl_reg <= serial_port_pkg::CTRL_RESET;
      end else if (fault_event) begin
         ctrl_reg[serial_port_pkg::CTRL_PERIPH_EN] <= 1'b0;
         ctrl_reg[serial_port_pkg::CTRL_MASTER]    <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl_reg <= wdata_reg[7:0];
         // Setting enable or master only allowed outside a fault or in its clearing write
         if (fault_reg && !fault_armed_reg) begin
            ctrl_reg[serial_port_pkg::CTRL_PERIPH_EN] <= 1'b0;
            ctrl_reg[serial_port_pkg::CTRL_MASTER]    <= 1'b0;
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         out_dis_reg    <= 1'b0;
         soft_mgmt_reg  <= 1'b0;
         soft_level_reg <= 1'b0;
      end else if (wr_stat) begin
         out_dis_reg    <= wdata_reg[serial_port_pkg::STAT_OUT_DIS];
         soft_mgmt_reg  <= wdata_reg[serial_port_pkg::STAT_SOFT_MGMT];
         soft_level_reg <= wdata_reg[serial_port_pkg::STAT_SOFT_LEVEL];
      end
   end

   // A status access arms the clearing sequences; status read or write both count
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         done_armed_reg  <= 1'b0;
         fault_armed_reg <= 1'b0;
         coll_armed_reg  <= 1'b0;
      end else begin
         if (rd_stat || wr_stat) begin
            done_armed_reg  <= done_reg;
            fault_armed_reg <= fault_reg;
            coll_armed_reg  <= coll_reg;
         end else begin
            if (wr_data || rd_data) begin
               done_armed_reg <= 1'b0;
               coll_armed_reg <= 1'b0;
            end
            if (wr_ctrl) begin
               fault_armed_reg <= 1'b0;
            end
         end
      end
   end

   // Data writes: refused while done is set and status not yet read or written
   assign data_load = wr_data && !(done_reg && !done_armed_reg) && state_reg == IDLE;

   // Serial engine
   assign half_period = half_div({ctrl_reg[serial_port_pkg::CTRL_DIV_EN],
                                  ctrl_reg[serial_port_pkg::CTRL_RATE_HI],
                                  ctrl_reg[serial_port_pkg::CTRL_RATE_LO]});
   assign master_tick = master && state_reg == RUN && div_cnt_reg == half_period;
   // Edge index counts clock transitions inside a byte: 0 is the first
   logic slave_edge;
   assign slave_edge  = !master && enabled && !sel_n && state_reg == RUN &&
                        (SCK_I != sck_in_prev_reg);
   logic any_edge;
   assign any_edge    = master_tick || slave_edge;
   assign sample_edge = any_edge &&
                        (edge_cnt_reg[0] == ctrl_reg[serial_port_pkg::CTRL_PHASE]);
   // First edge of a phase-one byte only launches the preloaded top bit; shifting there loses it
   assign shift_edge  = any_edge && !sample_edge && edge_cnt_reg != 4'd0;
   assign byte_end    = any_edge && edge_cnt_reg == 4'd15;

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         sck_in_prev_reg <= 1'b0;
         ss_in_prev_reg  <= 1'b1;
      end else begin
         sck_in_prev_reg <= SCK_I;
         ss_in_prev_reg  <= sel_n;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_reg    <= IDLE;
         edge_cnt_reg <= 4'd0;
         div_cnt_reg  <= 7'd0;
         sck_reg      <= 1'b0;
         shift_reg    <= serial_port_pkg::DATA_RESET;
         in_reg       <= 1'b0;
      end else begin
         unique case (state_reg)
            IDLE: begin
               sck_reg      <= ctrl_reg[serial_port_pkg::CTRL_POLARITY];
               edge_cnt_reg <= 4'd0;
               div_cnt_reg  <= 7'd0;
               if (data_load) begin
                  shift_reg <= wdata_reg[7:0];
                  // Master starts at once; slave waits for selection and clock
                  if (master && enabled) begin
                     state_reg <= RUN;
                  end
               end else if (!master && enabled && !sel_n && ss_in_prev_reg) begin
                  state_reg <= RUN;
               end else if (!master && enabled && !sel_n &&
                            !ctrl_reg[serial_port_pkg::CTRL_PHASE] &&
                            SCK_I != sck_in_prev_reg) begin
                  state_reg <= RUN;
               end
            end
            RUN: begin
               if (!enabled || (!master && sel_n)) begin
                  state_reg <= IDLE;
               end else begin
                  if (master) begin
                     div_cnt_reg <= master_tick ? 7'd0 : div_cnt_reg + 7'd1;
                     if (master_tick) begin
                        sck_reg <= !sck_reg;
                     end
                  end
                  if (any_edge) begin
                     edge_cnt_reg <= edge_cnt_reg + 4'd1;
                  end
                  if (sample_edge) begin
                     in_reg <= master ? MISO_I : MOSI_I;
                  end
                  // Shift in the captured bit, MSB first
                  if (shift_edge || byte_end) begin
                     shift_reg <= {shift_reg[6:0], sample_edge ? (master ? MISO_I : MOSI_I)
                                                               : in_reg};
                  end
                  if (byte_end) begin
                     state_reg <= IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Last bit lands in the buffer the same cycle done rises
   logic [7:0] rx_byte;
   assign rx_byte = {shift_reg[6:0], ctrl_reg[serial_port_pkg::CTRL_PHASE] ?
                     (master ? MISO_I : MOSI_I) : in_reg};

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rx_buf_reg <= serial_port_pkg::DATA_RESET;
      end else if (byte_end && !done_reg) begin
         rx_buf_reg <= rx_byte;
      end
   end

   // Flags: a hardware set wins over a software clear in the same cycle
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         done_reg  <= 1'b0;
         coll_reg  <= 1'b0;
         ovr_reg   <= 1'b0;
         fault_reg <= 1'b0;
      end else begin
         if (byte_end) begin
            done_reg <= 1'b1;
         end else if (done_armed_reg && (wr_data || rd_data)) begin
            done_reg <= 1'b0;
         end
         if (wr_data && state_reg == RUN) begin
            coll_reg <= 1'b1;
         end else if (coll_armed_reg && (wr_data || rd_data)) begin
            coll_reg <= 1'b0;
         end
         if (byte_end && done_reg) begin
            ovr_reg <= 1'b1;
         end else if (rd_stat) begin
            ovr_reg <= 1'b0;
         end
         if (fault_event) begin
            fault_reg <= 1'b1;
         end else if (fault_armed_reg && wr_ctrl) begin
            fault_reg <= 1'b0;
         end
      end
   end

   // Pins
   logic data_out_on;
   assign data_out_on   = enabled && !out_dis_reg;
   assign PINS_ALT_EN   = enabled;
   assign SS_PIN_ALT_EN = enabled && !soft_mgmt_reg;
   assign SCK_O         = sck_reg;
   assign SCK_OE_N      = !(enabled && master);
   assign MOSI_O        = shift_reg[7];
   assign MOSI_OE_N     = !(data_out_on && master);
   assign MISO_O        = shift_reg[7];
   assign MISO_OE_N     = !(data_out_on && !master && !sel_n);
   // Collision flag deliberately left out of the request
   assign IRQ = ctrl_reg[serial_port_pkg::CTRL_IRQ_EN] &&
                (done_reg || fault_reg || ovr_reg);
endmodule : serial_port

// ### bench/serial_port_chk.sv
// Checker for the serial port: pin enables, select handling and read channel.
// Assumes it is bound to serial_port; every signal belongs to CORE_CLK.
module serial_port_chk (
   input wire logic        CORE_CLK,
   input wire logic        RST_B,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0]  S_AXI_RRESP,
   input wire logic        S_AXI_RVALID,
   input wire logic        SCK_OE_N,
   input wire logic        MOSI_OE_N,
   input wire logic        MISO_OE_N,
   input wire logic        SS_N_I,
   input wire logic        PINS_ALT_EN,
   input wire logic        SS_PIN_ALT_EN
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   AST_PINS_OFF: assert property (!PINS_ALT_EN |-> SCK_OE_N && MOSI_OE_N && MISO_OE_N)
      else $error("serial pins driven while port disabled");
   // Select pin low as master must drop master and enable within a short sync delay
   AST_FAULT_DROP: assert property (!SCK_OE_N && SS_PIN_ALT_EN && !SS_N_I
      |-> ##[1:3] SCK_OE_N && !PINS_ALT_EN)
      else $error("master kept driving after select fault");
   AST_MASTER_OUT: assert property (!MOSI_OE_N |-> !SCK_OE_N)
      else $error("master data out driven without master clock");
   AST_SLAVE_OUT: assert property (!MISO_OE_N |-> SCK_OE_N && PINS_ALT_EN)
      else $error("slave data out driven outside slave mode");
   AST_SELECT: assert property (!MISO_OE_N && SS_PIN_ALT_EN |-> !SS_N_I)
      else $error("slave data out driven while pin deselected");
   AST_SS_PIN: assert property (SS_PIN_ALT_EN |-> PINS_ALT_EN)
      else $error("select pin claimed while port disabled");
   AST_R_WIDTH: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h00_0000)
      else $error("read data carries bits above the byte");
   AST_R_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   AST_R_ERRDATA: assert property (S_AXI_RVALID && S_AXI_RRESP == serial_port_pkg::AXI_SLVERR
      |-> S_AXI_RDATA == 32'h0000_0000)
      else $error("error read returned data");
endmodule : serial_port_chk

// ### bench/serial_far_dev.sv
// Far serial device: a slave answering the port's master clock, and a master task.
// Assumes serial pins sampled on CORE_CLK; the far master runs clock polarity 0, phase 0.
module serial_far_dev (
   input wire logic clk,
   input wire logic sck_o,
   input wire logic mosi_o,
   input wire logic miso_o,
   input wire logic miso_oe_n,
   output logic     sck_i,
   output logic     mosi_i,
   output logic     miso_i,
   output logic     ss_n_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] tx = 8'h00;
   logic [7:0] rx = 8'h00;
   logic       pol = 1'b0;
   logic       pha = 1'b0;
   int         k = 9;
   initial begin
      sck_i = 1'b0;
      mosi_i = 1'b0;
      ss_n_i = 1'b1;
   end
   task automatic arm(input logic [7:0] t, input logic p, input logic h);
      begin
         tx = t;
         pol = p;
         pha = h;
         k = h ? -1 : 0;
      end
   endtask : arm
   // Capture on the leading edge for phase 0, trailing for phase 1; shift on the other
   always @(sck_o) begin
      if ((sck_o != pol) ^ pha) rx = {rx[6:0], mosi_o};
      else k = k + 1;
   end
   // Outside a byte the line shows the inverse of the last bit, except after a phase-1 byte, where the last bit stays on it
   assign miso_i = (k >= 0 && k < 8) ? tx[7 - k] : ~tx[0];
   task automatic sel(input logic s);
      begin
         @(posedge clk);
         ss_n_i <= s;
      end
   endtask : sel
   // Clock idles low and stands still between bytes
   task automatic xfer(input logic [7:0] t, output logic [7:0] r);
      begin
         @(posedge clk);
         ss_n_i <= 1'b0;
         mosi_i <= t[7];
         repeat (4) @(posedge clk);
         for (int i = 0; i < 16; i++) begin
            sck_i <= ~sck_i;
            if (i % 2 == 0) r = {r[6:0], miso_oe_n ? 1'bz : miso_o};
            else if (i < 15) mosi_i <= t[6 - i / 2];
            repeat (4) @(posedge clk);
         end
         ss_n_i <= 1'b1;
         mosi_i <= ~mosi_i;
         repeat (4) @(posedge clk);
      end
   endtask : xfer
endmodule : serial_far_dev

// ### bench/serial_port_tb_top.sv
// Testbench top: AXI4-Lite register tasks and one task per scenario.
// Assumes the far device model drives all serial inputs; the checker is bound below.
module serial_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] DA = serial_port_pkg::DATA_ADDR;
   localparam logic [11:0] CA = serial_port_pkg::CTRL_ADDR;
   localparam logic [11:0] SA = serial_port_pkg::STATUS_ADDR;
   localparam logic [2:0] RATE [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
   localparam int DV [6] = '{4, 8, 16, 32, 64, 128};
   // Ready inputs held high: the master always accepts answers at once
   logic        CORE_CLK = 1'b0, RST_B = 1'b0, S_AXI_BREADY = 1'b1, S_AXI_RREADY = 1'b1;
   logic [11:0] S_AXI_AWADDR = 12'h000, S_AXI_ARADDR = 12'h000;
   logic [31:0] S_AXI_WDATA = 32'h0000_0000, S_AXI_RDATA;
   logic [3:0]  S_AXI_WSTRB = 4'hF;
   logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_ARVALID = 1'b0;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
   logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   logic        SCK_I, SCK_O, SCK_OE_N, MOSI_I, MOSI_O, MOSI_OE_N, MISO_I, MISO_O, MISO_OE_N;
   logic        SS_N_I, PINS_ALT_EN, SS_PIN_ALT_EN, IRQ;
   int          n_errors = 0, compares = 0;
   serial_port i_serial_port (.CORE_CLK, .RST_B, .S_AXI_AWADDR, .S_AXI_AWVALID,
      .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
      .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
      .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY,
      .SCK_I, .SCK_O, .SCK_OE_N, .MOSI_I, .MOSI_O, .MOSI_OE_N, .MISO_I, .MISO_O,
      .MISO_OE_N, .SS_N_I, .PINS_ALT_EN, .SS_PIN_ALT_EN, .IRQ);
   serial_far_dev i_serial_far_dev (.clk(CORE_CLK), .sck_o(SCK_O), .mosi_o(MOSI_O),
      .miso_o(MISO_O), .miso_oe_n(MISO_OE_N), .sck_i(SCK_I), .mosi_i(MOSI_I),
      .miso_i(MISO_I), .ss_n_i(SS_N_I));
   initial forever #10 CORE_CLK = ~CORE_CLK;
   task automatic conclude();
      begin
         if (n_errors == 0 && compares > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask : conclude
   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      begin
         compares++;
         if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask : chk
   // Ready is read at the falling edge: it cannot change again before the rising one
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      bit aw, w, b;
      begin
         S_AXI_AWADDR <= a;
         S_AXI_WDATA <= {24'h00_0000, d};
         S_AXI_AWVALID <= 1'b1;
         S_AXI_WVALID <= 1'b1;
         b = 0;
         for (int n = 0; n < 50 && !b; n++) begin
            @(negedge CORE_CLK);
            aw = S_AXI_AWVALID && S_AXI_AWREADY;
            w = S_AXI_WVALID && S_AXI_WREADY;
            b = S_AXI_BVALID;
            @(posedge CORE_CLK);
            if (aw) S_AXI_AWVALID <= 1'b0;
            if (w) S_AXI_WVALID <= 1'b0;
         end
         if (!b) chk("write answer", 8'h00, 8'h01);
      end
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      bit ar, r;
      begin
         S_AXI_ARADDR <= a;
         S_AXI_ARVALID <= 1'b1;
         r = 0;
         d = 8'h00;
         for (int n = 0; n < 50 && !r; n++) begin
            @(negedge CORE_CLK);
            ar = S_AXI_ARVALID && S_AXI_ARREADY;
            r = S_AXI_RVALID;
            d = S_AXI_RDATA[7:0];
            rsp = S_AXI_RRESP;
            @(posedge CORE_CLK);
            if (ar) S_AXI_ARVALID <= 1'b0;
         end
         if (!r) chk("read answer", 8'h00, 8'h01);
      end
   endtask : rd
   task automatic t_reset();
      logic [7:0] d;
      begin
         rd(CA, d);
         chk("ctrl reset", d & 8'hF0, 8'h00);
         rd(SA, d);
         chk("status reset", d, 8'h00);
         rd(12'h0D0, d);
         chk("unmapped resp", {6'h00, rsp}, {6'h00, serial_port_pkg::AXI_SLVERR});
         chk("unmapped data", d, 8'h00);
      end
   endtask : t_reset
   task automatic t_master(input int i);
      logic [7:0] c, tx, d;
      logic [2:0] e;
      int         n, k;
      logic       p;
      begin
         e = RATE[i];
         tx = 8'hA5 ^ 8'(i);
         c = {2'b11, e[2], 1'b1, i[1:0], e[1:0]};
         wr(CA, 8'h00);
         wr(CA, c);
         wr(SA, 8'h0F);
         chk("out disabled", {7'h00, MOSI_OE_N}, 8'h01);
         wr(SA, 8'h0B);
         chk("out enabled", {7'h00, MOSI_OE_N}, 8'h00);
         i_serial_far_dev.arm(~tx, c[3], c[2]);
         wr(DA, tx);
         n = 0;
         k = 0;
         p = SCK_O;
         while (k < 2 && n < 300) begin
            @(negedge CORE_CLK);
            n++;
            if (SCK_O !== p) begin
               p = SCK_O;
               k++;
               if (k == 1) n = 0;
            end
         end
         @(posedge CORE_CLK);
         chk("half period", 8'(n), 8'(DV[i] / 2));
         wr(DA, 8'h00);
         chk("irq on collision", {7'h00, IRQ}, 8'h00);
         for (n = 0; n < 3000 && IRQ !== 1'b1; n++) @(negedge CORE_CLK);
         @(posedge CORE_CLK);
         chk("irq done", {7'h00, IRQ}, 8'h01);
         chk("clock idle", {7'h00, SCK_O}, {7'h00, c[3]});
         chk("far rx", i_serial_far_dev.rx, tx);
         wr(DA, 8'h00);
         repeat (DV[i] / 2) @(posedge CORE_CLK);
         chk("no restart", {7'h00, SCK_O}, {7'h00, c[3]});
         rd(SA, d);
         chk("status flags", d, 8'hC3);
         rd(DA, d);
         chk("rx buffer", d, ~tx);
         rd(SA, d);
         chk("flags cleared", d, 8'h03);
      end
   endtask : t_master
   task automatic t_slave();
      logic [7:0] d;
      begin
         wr(CA, 8'h00);
         wr(SA, 8'h00);
         wr(CA, 8'h63);
         wr(DA, 8'h96);
         i_serial_far_dev.xfer(8'h5A, d);
         chk("slave tx", d, 8'h96);
         i_serial_far_dev.xfer(8'hC3, d);
         chk("irq masked", {7'h00, IRQ}, 8'h00);
         chk("deselected out", {7'h00, MISO_OE_N}, 8'h01);
         rd(SA, d);
         chk("overrun", d, 8'hA0);
         rd(DA, d);
         chk("kept byte", d, 8'h5A);
         rd(SA, d);
         chk("overrun cleared", d, 8'h00);
      end
   endtask : t_slave
   task automatic t_fault();
      logic [7:0] d;
      begin
         wr(CA, 8'h00);
         wr(SA, 8'h00);
         wr(CA, 8'hD0);
         i_serial_far_dev.sel(1'b0);
         repeat (4) @(posedge CORE_CLK);
         chk("fault pins", {7'h00, PINS_ALT_EN}, 8'h00);
         chk("fault irq", {7'h00, IRQ}, 8'h01);
         wr(CA, 8'hD0);
         rd(CA, d);
         chk("blocked ctrl", d, 8'h80);
         i_serial_far_dev.sel(1'b1);
         rd(SA, d);
         chk("fault flag", d, 8'h10);
         wr(CA, 8'hD0);
         rd(CA, d);
         chk("restored ctrl", d, 8'hD0);
         rd(SA, d);
         chk("fault cleared", d, 8'h00);
         chk("irq cleared", {7'h00, IRQ}, 8'h00);
      end
   endtask : t_fault
   initial begin
      repeat (3) @(posedge CORE_CLK);
      RST_B <= 1'b1;
      @(posedge CORE_CLK);
      t_reset();
      for (int i = 0; i < 6; i++) t_master(i);
      t_slave();
      t_fault();
      conclude();
   end
   // About twenty times the expected run of some two and a half thousand cycles
   initial begin
      #1ms;
      n_errors++;
      conclude();
   end
endmodule : serial_port_tb_top
bind serial_port serial_port_chk i_serial_port_chk (.CORE_CLK, .RST_B, .S_AXI_ARVALID,
   .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .SCK_OE_N, .MOSI_OE_N,
   .MISO_OE_N, .SS_N_I, .PINS_ALT_EN, .SS_PIN_ALT_EN);
